// *** verilog/bsf_pkg.sv ***
package bsf_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 200;
  localparam int T_OC_NS = 10000;
  localparam int T_OV_NS = 2000;
  localparam int T_UV_NS = 2000;
  localparam int T_SS_DELAY_NS = 20000;
  localparam int CYC_OC = (T_OC_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_OV = (T_OV_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_UV = (T_UV_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_SS_DELAY = (T_SS_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 12;

  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_EXT_MODE_BIT = 0;
  localparam int CTRL_EXT_LVL_LSB = 8;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_DONE_BIT = 8;
  localparam int ST_OC_BIT = 9;
  localparam int ST_OV_BIT = 10;
  localparam int ST_UV_BIT = 11;
  localparam int ST_OT_BIT = 12;
  localparam int ST_CODE_LSB = 16;
  localparam int ST_TARGET_LSB = 24;

  // Power-ok pull-down codes
  localparam logic [1:0] PG_NONE = 2'h0;
  localparam logic [1:0] PG_95 = 2'h1;
  localparam logic [1:0] PG_65 = 2'h2;
  localparam logic [1:0] PG_35 = 2'h3;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_DELAY = 5'h02,
    ST_SOFT = 5'h04,
    ST_RUN = 5'h08,
    ST_LATCH = 5'h10
  } bsf_state_t;
endpackage : bsf_pkg

// *** verilog/bsf_supervisor.sv ***
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
// What this block does
// - Release ramp clamp, enable amplifier after qualification
// - Soft-start ramps on the limited charging source
// - Target taken from selection at enable
// - Ramp at target: done flag, power-ok high
// - After soft-start, slew to new setpoints bidirectionally
// - Overcurrent beyond 10 us latches converter off
// - Overcurrent code; cleared by enable or supply
// - Overvoltage above rising threshold beyond 2 us
// - Overvoltage code; cleared only by supply
// - Overvoltage latch toggles low-side gate with deglitch
// - Undervoltage below threshold beyond 2 us
// - Undervoltage code; cleared by enable or supply
// - Over-temperature forces gates low, no latch
// - Over-temperature ends on hysteresis, enable, supply
// - Ramp starts 20 us later; diode emulation inhibited
// - Power-ok shows 95 code during soft-start
module bsf_supervisor (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic supply_ok_i,
  input wire logic enable_ok_i,
  input wire logic [1:0] voltage_select_inputs_i,
  input wire logic oc_above_i,
  input wire logic fb_above_ov_rise_i,
  input wire logic fb_above_ov_fall_i,
  input wire logic fb_below_uv_i,
  input wire logic temp_above_rise_i,
  input wire logic temp_below_hys_i,
  input wire logic ramp_at_target_i,
  input wire logic pwm_high_i,
  input wire logic pwm_low_i,
  output logic ref_release_o,
  output logic softstart_source_en_o,
  output logic voltage_step_source_en_o,
  output logic voltage_step_charge_o,
  output logic [7:0] setpoint_select_o,
  output logic softstart_done_flag_o,
  output logic diode_emul_inhibit_o,
  output logic power_ok_release_o,
  output logic [1:0] power_ok_code_o,
  output logic high_side_gate_drive_o,
  output logic low_side_gate_drive_o
);
  localparam int NS = 11;
  localparam int ND = 4;
  localparam logic [ND*bsf_pkg::TMR_W-1:0] LIMS = {
    bsf_pkg::TMR_W'(bsf_pkg::CYC_UV), bsf_pkg::TMR_W'(bsf_pkg::CYC_OV),
    bsf_pkg::TMR_W'(bsf_pkg::CYC_OV), bsf_pkg::TMR_W'(bsf_pkg::CYC_OC)};

  // Two-stage synchroniser for all analog comparator levels
  logic [NS-1:0] meta_r;
  logic [NS-1:0] sync_r;
  wire [NS-1:0] raw = {ramp_at_target_i, temp_below_hys_i, temp_above_rise_i, fb_below_uv_i,
    fb_above_ov_fall_i, fb_above_ov_rise_i, oc_above_i, voltage_select_inputs_i, enable_ok_i, supply_ok_i};
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end
  wire supply_s = sync_r[0];
  wire enable_s = sync_r[1];
  wire [1:0] vsel_s = sync_r[3:2];
  wire at_target_s = sync_r[10];
  wire temp_hi_s = sync_r[8];
  wire temp_cool_s = sync_r[9];
  // Deglitch conditions: overcurrent, above ov rise, below ov fall, below uv
  wire [ND-1:0] dg_cond = {sync_r[7], ~sync_r[6], sync_r[5], sync_r[4]};
  logic [ND-1:0] dg_hit;

  genvar gi;
  generate
    for (gi = 0; gi < ND; gi++) begin : g_dg
      logic [bsf_pkg::TMR_W-1:0] cnt_r;
      wire [bsf_pkg::TMR_W-1:0] lim = LIMS[gi*bsf_pkg::TMR_W +: bsf_pkg::TMR_W];
      // Counter saturates so a long condition keeps the hit asserted
      wire [bsf_pkg::TMR_W-1:0] cnt_nxt = !dg_cond[gi] ? '0 : (cnt_r == lim) ? cnt_r :
        cnt_r + bsf_pkg::TMR_W'(1);
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
      // Hit only once the level has outlasted the full interval
      assign dg_hit[gi] = dg_cond[gi] && (cnt_r == lim);
    end
  endgenerate
  wire oc_hit = dg_hit[0];
  wire ov_rise_hit = dg_hit[1];
  wire ov_fall_hit = dg_hit[2];
  wire uv_hit = dg_hit[3];

  // Register file
  logic [31:0] ctrl_r;
  wire apb_setup = psel_i && !penable_i;
  wire apb_wr = psel_i && penable_i && pready_o && pwrite_i;
  wire sel_ctrl = paddr_i == bsf_pkg::ADDR_CTRL;
  wire sel_status = paddr_i == bsf_pkg::ADDR_STATUS;
  wire ctrl_nxt_en = apb_wr && sel_ctrl;
  wire ext_mode = ctrl_r[bsf_pkg::CTRL_EXT_MODE_BIT];
  wire [7:0] ext_level = ctrl_r[bsf_pkg::CTRL_EXT_LVL_LSB +: 8];

  // Selection code 00 is the highest setpoint; invert so larger means higher
  wire [7:0] request = ext_mode ? ext_level : {6'h00, ~vsel_s};

  bsf_pkg::bsf_state_t state_r;
  bsf_pkg::bsf_state_t state_nxt;
  logic [bsf_pkg::TMR_W-1:0] delay_r;
  logic [7:0] target_r;
  logic oc_lat_r;
  logic ov_lat_r;
  logic uv_lat_r;
  logic ot_r;
  logic ov_lg_r;
  logic [1:0] first_r;
  logic charge_r;

  wire alive = supply_s && enable_s;
  wire converting = (state_r == bsf_pkg::ST_SOFT) || (state_r == bsf_pkg::ST_RUN);
  wire oc_set = converting && oc_hit;
  wire ov_set = converting && ov_rise_hit;
  // Undervoltage watch starts after soft-start, the ramp sits below it before
  wire uv_set = (state_r == bsf_pkg::ST_RUN) && uv_hit;
  wire oc_lat_nxt = oc_set || (oc_lat_r && alive);
  wire ov_lat_nxt = ov_set || (ov_lat_r && supply_s);
  wire uv_lat_nxt = uv_set || (uv_lat_r && alive);
  wire any_lat = oc_lat_r || ov_lat_r || uv_lat_r;
  wire any_set = oc_set || ov_set || uv_set;
  wire delay_done = delay_r == bsf_pkg::TMR_W'(bsf_pkg::CYC_SS_DELAY - 1);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      bsf_pkg::ST_OFF: begin
        if (alive && !any_lat) begin
          state_nxt = bsf_pkg::ST_DELAY;
        end
      end
      bsf_pkg::ST_DELAY: begin
        if (!alive) begin
          state_nxt = bsf_pkg::ST_OFF;
        end else if (delay_done) begin
          state_nxt = bsf_pkg::ST_SOFT;
        end
      end
      bsf_pkg::ST_SOFT: begin
        if (any_set) begin
          state_nxt = bsf_pkg::ST_LATCH;
        end else if (!alive) begin
          state_nxt = bsf_pkg::ST_OFF;
        end else if (at_target_s) begin
          state_nxt = bsf_pkg::ST_RUN;
        end
      end
      bsf_pkg::ST_RUN: begin
        if (any_set) begin
          state_nxt = bsf_pkg::ST_LATCH;
        end else if (!alive) begin
          state_nxt = bsf_pkg::ST_OFF;
        end
      end
      bsf_pkg::ST_LATCH: begin
        if (!oc_lat_nxt && !ov_lat_nxt && !uv_lat_nxt) begin
          state_nxt = bsf_pkg::ST_OFF;
        end
      end
    endcase
  end

  // Target captured at enable, followed only after soft-start
  wire capture = (state_r == bsf_pkg::ST_OFF) && (state_nxt == bsf_pkg::ST_DELAY);
  wire step_req = (state_r == bsf_pkg::ST_RUN) && (request != target_r);
  wire [7:0] target_nxt = (capture || step_req) ? request : target_r;
  wire charge_nxt = step_req ? (request > target_r) : charge_r;
  wire [bsf_pkg::TMR_W-1:0] delay_nxt = (state_r == bsf_pkg::ST_DELAY) ? delay_r + bsf_pkg::TMR_W'(1) : '0;

  // Over-temperature is a non-latching suspend
  wire ot_nxt = alive && (ot_r ? !temp_cool_s : temp_hi_s);
  // Low-side toggles while latched for overvoltage
  wire ov_lg_nxt = ov_lat_nxt && (ov_rise_hit || (ov_lg_r && !ov_fall_hit));

  // Keep first code while its latch holds; fall back to a survivor otherwise
  wire [1:0] enc_nxt = oc_lat_nxt ? bsf_pkg::PG_35 : ov_lat_nxt ? bsf_pkg::PG_65 :
    uv_lat_nxt ? bsf_pkg::PG_95 : bsf_pkg::PG_NONE;
  wire first_kept = ((first_r == bsf_pkg::PG_35) && oc_lat_nxt) || ((first_r == bsf_pkg::PG_65) && ov_lat_nxt)
    || ((first_r == bsf_pkg::PG_95) && uv_lat_nxt);
  wire [1:0] first_nxt = first_kept ? first_r : enc_nxt;

  // Output next values
  wire st_delay_n = state_nxt == bsf_pkg::ST_DELAY;
  wire st_soft_n = state_nxt == bsf_pkg::ST_SOFT;
  wire st_run_n = state_nxt == bsf_pkg::ST_RUN;
  wire conv_n = st_soft_n || st_run_n;
  wire lat_n = oc_lat_nxt || ov_lat_nxt || uv_lat_nxt;
  wire ref_release_nxt = st_delay_n || conv_n;
  wire ss_src_nxt = st_soft_n;
  wire run_done_nxt = st_run_n && !lat_n;
  wire [1:0] pg_code_nxt = lat_n ? first_nxt : (supply_s && !run_done_nxt) ? bsf_pkg::PG_95
    : bsf_pkg::PG_NONE;
  wire ug_nxt = conv_n && !ot_nxt && pwm_high_i;
  // Over-temperature overrides the overvoltage discharge as well
  wire lg_nxt = !ot_nxt && (ov_lat_nxt ? ov_lg_nxt : (conv_n && pwm_low_i));

  // Status word for software
  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[bsf_pkg::ST_STATE_LSB +: 5] = state_r;
    status[bsf_pkg::ST_DONE_BIT] = softstart_done_flag_o;
    status[bsf_pkg::ST_OC_BIT] = oc_lat_r;
    status[bsf_pkg::ST_OV_BIT] = ov_lat_r;
    status[bsf_pkg::ST_UV_BIT] = uv_lat_r;
    status[bsf_pkg::ST_OT_BIT] = ot_r;
    status[bsf_pkg::ST_CODE_LSB +: 2] = first_r;
    status[bsf_pkg::ST_TARGET_LSB +: 8] = target_r;
  end
  wire [31:0] rdata_nxt = sel_ctrl ? ctrl_r : sel_status ? status : 32'h0000_0000;
  wire err_nxt = !(sel_ctrl || sel_status);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r <= bsf_pkg::CTRL_RESET;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      if (ctrl_nxt_en) begin
        ctrl_r <= pwdata_i;
      end
      if (apb_setup) begin
        prdata_o <= rdata_nxt;
        pslverr_o <= err_nxt;
      end
      pready_o <= apb_setup;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= bsf_pkg::ST_OFF;
      delay_r <= '0;
      target_r <= 8'h00;
      charge_r <= 1'b0;
      oc_lat_r <= 1'b0;
      ov_lat_r <= 1'b0;
      uv_lat_r <= 1'b0;
      ot_r <= 1'b0;
      ov_lg_r <= 1'b0;
      first_r <= bsf_pkg::PG_NONE;
    end else begin
      state_r <= state_nxt;
      delay_r <= delay_nxt;
      target_r <= target_nxt;
      charge_r <= charge_nxt;
      oc_lat_r <= oc_lat_nxt;
      ov_lat_r <= ov_lat_nxt;
      uv_lat_r <= uv_lat_nxt;
      ot_r <= ot_nxt;
      ov_lg_r <= ov_lg_nxt;
      first_r <= first_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_release_o <= 1'b0;
      softstart_source_en_o <= 1'b0;
      voltage_step_source_en_o <= 1'b0;
      voltage_step_charge_o <= 1'b0;
      setpoint_select_o <= 8'h00;
      softstart_done_flag_o <= 1'b0;
      diode_emul_inhibit_o <= 1'b0;
      power_ok_release_o <= 1'b0;
      power_ok_code_o <= bsf_pkg::PG_NONE;
      high_side_gate_drive_o <= 1'b0;
      low_side_gate_drive_o <= 1'b0;
    end else begin
      ref_release_o <= ref_release_nxt;
      softstart_source_en_o <= ss_src_nxt;
      voltage_step_source_en_o <= run_done_nxt;
      voltage_step_charge_o <= charge_nxt;
      setpoint_select_o <= target_nxt;
      softstart_done_flag_o <= run_done_nxt;
      diode_emul_inhibit_o <= st_delay_n || st_soft_n;
      power_ok_release_o <= run_done_nxt;
      power_ok_code_o <= pg_code_nxt;
      high_side_gate_drive_o <= ug_nxt;
      low_side_gate_drive_o <= lg_nxt;
    end
  end
endmodule : bsf_supervisor

// *** bench/bsf_power_stage.sv ***
`timescale 1ns/10ps
module bsf_power_stage #(
  parameter int RAMP_CYC = 50
) (
  input wire logic sys_clk_i,
  input wire logic softstart_source_en_i,
  input wire logic ref_release_i,
  output logic ramp_at_target_o
);
  int cnt_r;
  // Clamp empties the capacitor, so each restart ramps from zero
  always_ff @(posedge sys_clk_i) begin
    if (!ref_release_i) begin
      cnt_r <= 0;
    end else if (softstart_source_en_i && cnt_r < RAMP_CYC) begin
      cnt_r <= cnt_r + 1;
    end
  end
  assign ramp_at_target_o = (cnt_r == RAMP_CYC);
endmodule : bsf_power_stage

// *** bench/bsf_supervisor_props.sv ***
`timescale 1ns/10ps
module bsf_supervisor_props (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic supply_ok_i,
  input wire logic enable_ok_i,
  input wire logic oc_above_i,
  input wire logic temp_above_rise_i,
  input wire logic ref_release_o,
  input wire logic softstart_source_en_o,
  input wire logic voltage_step_source_en_o,
  input wire logic softstart_done_flag_o,
  input wire logic diode_emul_inhibit_o,
  input wire logic power_ok_release_o,
  input wire logic [1:0] power_ok_code_o,
  input wire logic high_side_gate_drive_o,
  input wire logic low_side_gate_drive_o
);
  int dly_r;
  int oc_r;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dly_r <= 0;
      oc_r <= 0;
    end else begin
      dly_r <= (ref_release_o && !softstart_source_en_o && !softstart_done_flag_o) ? dly_r + 1 : 0;
      oc_r <= oc_above_i ? oc_r + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_apb_one_wait: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  a_release_qualified: assert property ($rose(ref_release_o) |-> supply_ok_i && enable_ok_i)
    else $error("release without qualification");
  a_delay_span: assert property ($rose(softstart_source_en_o) |-> dly_r inside {[3999:4001]})
    else $error("ramp start delay wrong");
  a_soft_mode: assert property (softstart_source_en_o |-> diode_emul_inhibit_o && !power_ok_release_o
    && power_ok_code_o == bsf_pkg::PG_95) else $error("soft-start mode outputs wrong");
  a_done_ok: assert property ($rose(softstart_done_flag_o) |-> power_ok_release_o && voltage_step_source_en_o
    && !softstart_source_en_o && power_ok_code_o == bsf_pkg::PG_NONE) else $error("done handover wrong");
  a_oc_deglitch: assert property ($rose(power_ok_code_o == bsf_pkg::PG_35) |-> oc_r > bsf_pkg::CYC_OC)
    else $error("overcurrent tripped early");
  a_oc_off: assert property (power_ok_code_o == bsf_pkg::PG_35 |-> !power_ok_release_o && !ref_release_o)
    else $error("overcurrent not latched off");
  a_ov_holds: assert property (supply_ok_i[*4] ##0 power_ok_code_o == bsf_pkg::PG_65 |=>
    power_ok_code_o == bsf_pkg::PG_65) else $error("overvoltage code lost");
  a_ot_gates: assert property (temp_above_rise_i[*6] |-> !high_side_gate_drive_o && !low_side_gate_drive_o)
    else $error("gate on in over-temperature");
  c_done: cover property ($rose(softstart_done_flag_o));
  c_ov: cover property ($rose(power_ok_code_o == bsf_pkg::PG_65));
  c_oc: cover property ($rose(power_ok_code_o == bsf_pkg::PG_35));
endmodule : bsf_supervisor_props

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  logic sys_clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic pready_o, pslverr_o, ref_release_o, softstart_source_en_o, voltage_step_source_en_o, voltage_step_charge_o;
  logic softstart_done_flag_o, diode_emul_inhibit_o, power_ok_release_o, high_side_gate_drive_o, low_side_gate_drive_o;
  logic [7:0] setpoint_select_o;
  logic [1:0] power_ok_code_o, voltage_select_inputs_i = 2'h3;
  logic supply_ok_i = 0, enable_ok_i = 0, oc_above_i = 0, fb_above_ov_rise_i = 0, fb_above_ov_fall_i = 0;
  logic fb_below_uv_i = 0, temp_above_rise_i = 0, temp_below_hys_i = 1, ramp_at_target_i, pwm_high_i = 1;
  logic pwm_low_i = 0;
  logic [1:0] r_sel [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  logic [8:0] r_exp [4] = '{9'h103, 9'h001, 9'h102, 9'h000};
  int n_mismatch = 0, checks_done = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  bsf_supervisor bsf_supervisor_inst (.*);
  bsf_power_stage bsf_power_stage_inst (.sys_clk_i(sys_clk_i), .softstart_source_en_i(softstart_source_en_o),
    .ref_release_i(ref_release_o), .ramp_at_target_o(ramp_at_target_i));
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : step
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  task automatic start(input logic [1:0] sel);
    voltage_select_inputs_i <= sel;
    supply_ok_i <= 1;
    enable_ok_i <= 1;
    step(4);
    chk("release", {ref_release_o, diode_emul_inhibit_o, power_ok_code_o}, 4'hd);
    step(4002);
    chk("ss_source", softstart_source_en_o, 1);
    voltage_select_inputs_i <= ~sel;
    step(10);
    chk("target_kept", setpoint_select_o, {6'h0, ~sel});
    voltage_select_inputs_i <= sel;
    step(70);
    chk("done", {softstart_done_flag_o, power_ok_release_o, power_ok_code_o}, 4'hc);
  endtask : start
  task automatic latches_clear();
    // Let the lowered enable or supply pass the synchroniser first
    step(4);
    apb(0, bsf_pkg::ADDR_STATUS, 0);
    chk("latches", rd[12:9], 0);
  endtask : latches_clear
  task automatic results();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    step(2);
    reset_i <= 0;
    step(3);
    chk("por", {ref_release_o, power_ok_code_o}, 0);
    start(2'h3);
    for (int i = 0; i < 4; i++) begin
      voltage_select_inputs_i <= r_sel[i];
      step(5);
      chk("step", {voltage_step_charge_o, setpoint_select_o}, r_exp[i]);
    end
    apb(1, bsf_pkg::ADDR_CTRL, 32'h5a01);
    step(3);
    chk("ext_step", {voltage_step_charge_o, setpoint_select_o}, 9'h15a);
    apb(0, bsf_pkg::ADDR_CTRL, 0);
    chk("ctrl_rd", rd, 32'h5a01);
    apb(0, bsf_pkg::ADDR_STATUS, 0);
    chk("status_run", rd[8:0], 9'h108);
    apb(1, 12'h008, 32'hffff);
    chk("unmapped_err", err, 1);
    chk("unmapped_rd", rd, 0);
    apb(0, bsf_pkg::ADDR_CTRL, 0);
    chk("unmapped_wr", rd, 32'h5a01);
    apb(1, bsf_pkg::ADDR_CTRL, 0);
    // Over-temperature held by missing hysteresis, so only enable or supply can end it
    temp_below_hys_i <= 0;
    temp_above_rise_i <= 1;
    step(8);
    chk("ot", {high_side_gate_drive_o, power_ok_release_o}, 2'h1);
    temp_above_rise_i <= 0;
    fb_below_uv_i <= 1;
    step(410);
    chk("uv_code", power_ok_code_o, 1);
    fb_below_uv_i <= 0;
    enable_ok_i <= 0;
    latches_clear();
    start(2'h3);
    chk("ot_left", high_side_gate_drive_o, 1);
    fb_above_ov_rise_i <= 1;
    fb_above_ov_fall_i <= 1;
    step(410);
    chk("ov_code", power_ok_code_o, 2);
    enable_ok_i <= 0;
    step(420);
    chk("ov_hold", {power_ok_code_o, low_side_gate_drive_o}, 3'h5);
    fb_above_ov_rise_i <= 0;
    fb_above_ov_fall_i <= 0;
    step(410);
    chk("ov_low_side_gate_drive_off", low_side_gate_drive_o, 0);
    supply_ok_i <= 0;
    step(5);
    chk("ov_clear", power_ok_code_o, 0);
    start(2'h0);
    // Low-side command path and the hysteresis exit of over-temperature
    pwm_low_i <= 1;
    temp_above_rise_i <= 1;
    step(8);
    chk("ot_gates", {high_side_gate_drive_o, low_side_gate_drive_o}, 0);
    temp_above_rise_i <= 0;
    temp_below_hys_i <= 1;
    step(8);
    chk("ot_hys", {high_side_gate_drive_o, low_side_gate_drive_o}, 2'h3);
    pwm_low_i <= 0;
    oc_above_i <= 1;
    step(1990);
    chk("oc_early", power_ok_code_o, 0);
    step(20);
    chk("oc_code", power_ok_code_o, 3);
    oc_above_i <= 0;
    enable_ok_i <= 0;
    latches_clear();
    results();
  end
  initial begin
    step(30000);
    n_mismatch++;
    results();
  end
endmodule : tb_top
bind bsf_supervisor bsf_supervisor_props bsf_supervisor_props_inst (.*);
